// File: verification/dbg_asserts.sv
// port assertions for the core debug logic
// assumes it is bound onto cpu_debug_logic, one clock domain on pclk
`timescale 1ns/1ps
`default_nettype none
module dbg_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic debug_event,
	input wire logic retire_valid,
	input wire logic [31:0] retire_pc,
	input wire dbg_pkg::trace_t trace_out,
	input wire logic dbg_exception,
	input wire logic core_step,
	input wire logic core_halt,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic ic_we,
	input wire logic [31:0] ic_addr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// no wait states: answer in the first access cycle and only there
	chk_apb_ready_now: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	chk_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access cycle");
	// trace is always on, one cycle behind retirement
	chk_trace_pc: assert property (retire_valid |=> trace_out.valid
		&& trace_out.pc == $past(retire_pc))
		else $error("trace lost a retired pc");
	chk_trace_quiet: assert property (!retire_valid |=> !trace_out.valid)
		else $error("trace without retirement");
	// exception is a one-cycle pulse; a breakpoint hit needs a retirement as its cause
	chk_exc_cause: assert property (dbg_exception |-> $past(debug_event || retire_valid)
		##1 !dbg_exception)
		else $error("exception without event");
	chk_exc_trigger: assert property (dbg_exception |-> trace_out.trigger)
		else $error("event not flagged to trace");
	chk_step_single: assert property (core_step |-> !core_halt ##1 !core_step)
		else $error("step not a single run pulse");
	// a fetch lands in the instruction cache next cycle unless an OP_IC_WR takes the port in the same cycle
	chk_fetch_fill: assert property (fetch_valid |=> ic_we
		&& ic_addr == $past(fetch_addr))
		else $error("fetch not written to cache");
endmodule : dbg_asserts
`default_nettype wire

// File: verification/jtag_tool.sv
// debug tool model: 40-bit frames on the serial test port, msb first
// assumes the device oversamples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module jtag_tool (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	logic [39:0] rx;

	// idle: clock parked low, frame marker high
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		rx = '0;
	end

	// 160 ns link period, unrelated in phase; the clock only runs inside a frame
	task send(input logic [7:0] op, input logic [31:0] arg);
		logic [39:0] f;
		f = {op, arg};
		#13 tms = 1'b0;
		for (int i = 39; i >= 0; i--)
		begin
			tdi = f[i];
			#80 tck = 1'b1;
			rx = {rx[38:0], tdo};
			#80 tck = 1'b0;
		end
		tms = 1'b1;
		tdi = ~tdi; // released line must not show a stale bit
		#300;
	endtask : send
endmodule : jtag_tool
`default_nettype wire

// File: verification/tb_top.sv
// top bench: apb master, serial tool model, core side stubs
// assumes dbg_pkg, cpu_debug_logic, jtag_tool and dbg_asserts compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, debug_event, retire_valid, slv;
	logic core_irq, irq_done, fetch_valid, jtag_tck, jtag_tms, jtag_tdi, got_exc;
	logic [7:0] paddr;
	logic [31:0] pwdata, retire_pc, res_rdata, fetch_addr, fetch_data, rdata, got_wd, got_ic;
	logic [31:0] prdata, res_addr, res_wdata, ic_addr, ic_data;
	logic pready, pslverr, irq, jtag_tdo, jtag_tdo_oe_n, core_halt, core_step;
	logic timer_freeze, dbg_exception, res_we, res_re, ic_we;
	dbg_pkg::trace_t trace_out;
	int failures, n_checks, cyc, n_step, n_trig;

	cpu_debug_logic uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .irq, .jtag_tck, .jtag_tms, .jtag_tdi, .jtag_tdo,
		.jtag_tdo_oe_n, .debug_event, .retire_valid, .retire_pc, .core_irq, .irq_done,
		.res_rdata, .core_halt, .core_step, .timer_freeze, .dbg_exception, .res_addr,
		.res_wdata, .res_we, .res_re, .fetch_valid, .fetch_addr, .fetch_data, .ic_we,
		.ic_addr, .ic_data, .trace_out);
	// tdo has no pull-up: while released the tool sees the inverse, never a kept bit
	jtag_tool tool (.tck(jtag_tck), .tms(jtag_tms), .tdi(jtag_tdi),
		.tdo(jtag_tdo_oe_n ? ~jtag_tdo : jtag_tdo));

	// 50 MHz core clock
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// latch core-side pulses for later checks; cut a hang short
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (res_we) got_wd <= res_wdata;
		if (ic_we) got_ic <= ic_data;
		if (core_step) n_step <= n_step + 1;
		if (dbg_exception) got_exc <= 1'b1;
		if (trace_out.trigger) n_trig <= n_trig + 1;
		if (cyc == 12000)
		begin
			failures++;
			wrap_up();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// request held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask : rchk
	// debug event pulse; caller sits just after an edge
	task evt();
		debug_event <= 1'b1;
		tick(1);
		debug_event <= 1'b0;
		tick(3);
	endtask : evt
	task done(input string s);
		$display("test %0s done", s);
	endtask : done
	task wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// main sequence
	initial
	begin
		{psel, penable, pwrite, debug_event, retire_valid, core_irq, irq_done} = '0;
		{fetch_valid, got_exc, presetn, paddr, pwdata, retire_pc, fetch_addr} = '0;
		{fetch_data, got_wd, got_ic} = '0;
		{failures, n_checks, cyc, n_step, n_trig} = '0;
		res_rdata = 32'h5A5A_0F0F;
		tick(16);
		presetn <= 1'b1;
		rchk(dbg_pkg::OFF_CTRL, 32'h0);
		rchk(dbg_pkg::OFF_STATUS, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, slv}, 32'h1);
		apb(1'b1, dbg_pkg::OFF_CTRL, 32'h3);
		rchk(dbg_pkg::OFF_CTRL, 32'h0);
		apb(1'b1, dbg_pkg::OFF_DATA, 32'h1234_5678);
		rchk(dbg_pkg::OFF_DATA, 32'h1234_5678);
		done("registers");
		evt();
		chk({31'h0, got_exc}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rchk(dbg_pkg::OFF_IRQ_STAT, 32'h1);
		apb(1'b1, dbg_pkg::OFF_IRQ_MASK, 32'h1);
		tick(1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, dbg_pkg::OFF_IRQ_STAT, 32'h1);
		tick(1);
		chk({31'h0, irq}, 32'h0);
		// software commands are taken in internal mode
		apb(1'b1, dbg_pkg::OFF_CMD, {24'h0, dbg_pkg::OP_FREEZE});
		rchk(dbg_pkg::OFF_STATUS, 32'h8);
		apb(1'b1, dbg_pkg::OFF_CMD, {24'h0, dbg_pkg::OP_THAW});
		rchk(dbg_pkg::OFF_STATUS, 32'h0);
		done("internal");
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, dbg_pkg::OFF_CTRL, i ? 32'h4 : 32'h0);
			fetch_valid <= 1'b1;
			fetch_addr <= 32'h0000_0100;
			fetch_data <= 32'h1122_3344;
			tick(1);
			fetch_valid <= 1'b0;
			tick(2);
			chk(got_ic, i ? 32'h4433_2211 : 32'h1122_3344);
		end
		done("endian");
		tool.send(dbg_pkg::OP_SET_MODE, 32'h1);
		tick(1);
		rchk(dbg_pkg::OFF_CTRL, 32'h5);
		chk({31'h0, jtag_tdo_oe_n}, 32'h1);
		apb(1'b1, dbg_pkg::OFF_CMD, {24'h0, dbg_pkg::OP_FREEZE});
		rchk(dbg_pkg::OFF_STATUS, 32'h0);
		evt();
		chk({31'h0, core_halt}, 32'h1);
		rchk(dbg_pkg::OFF_STATUS, 32'h1);
		tool.send(dbg_pkg::OP_FREEZE, 32'h0);
		tick(1);
		rchk(dbg_pkg::OFF_STATUS, 32'h9);
		chk({31'h0, timer_freeze}, 32'h1);
		tool.send(dbg_pkg::OP_THAW, 32'h0);
		tick(1);
		chk({31'h0, timer_freeze}, 32'h0);
		tool.send(dbg_pkg::OP_STEP, 32'h0);
		tick(1);
		chk(n_step, 32'h1);
		rchk(dbg_pkg::OFF_STATUS, 32'h3);
		retire_valid <= 1'b1;
		retire_pc <= 32'h0000_0200;
		tick(1);
		retire_valid <= 1'b0;
		tick(2);
		rchk(dbg_pkg::OFF_STATUS, 32'h1);
		tool.send(dbg_pkg::OP_RUN, 32'h0);
		tick(1);
		rchk(dbg_pkg::OFF_STATUS, 32'h0);
		done("external");
		// a breakpoint set by the tool stops the core when that pc retires
		tool.send(dbg_pkg::OP_SET_BP, 32'h0000_0300);
		tick(1);
		rchk(dbg_pkg::OFF_CTRL, 32'hD);
		rchk(dbg_pkg::OFF_BP, 32'h0000_0300);
		retire_valid <= 1'b1;
		retire_pc <= 32'h0000_0300;
		tick(1);
		retire_valid <= 1'b0;
		tick(2);
		chk({31'h0, core_halt}, 32'h1);
		rchk(dbg_pkg::OFF_STATUS, 32'h1);
		tool.send(dbg_pkg::OP_RUN, 32'h0);
		tick(1);
		rchk(dbg_pkg::OFF_STATUS, 32'h0);
		done("breakpoint");
		tool.send(dbg_pkg::OP_SET_ADDR, 32'h0000_0040);
		tool.send(dbg_pkg::OP_RES_WR, 32'hCAFE_0001);
		tick(1);
		chk(got_wd, 32'hCAFE_0001);
		chk(res_addr, 32'h0000_0040);
		tool.send(dbg_pkg::OP_RES_RD, 32'h0);
		tick(1);
		rchk(dbg_pkg::OFF_DATA, 32'h5A5A_0F0F);
		tool.send(dbg_pkg::OP_IC_WR, 32'h6000_0001);
		tick(1);
		chk(got_ic, 32'h6000_0001);
		chk(ic_addr, 32'h0000_0040);
		chk(res_addr, 32'h0000_0044);
		done("resources");
		// this frame shifts out the reply loaded as the cache write frame ended
		tool.send(dbg_pkg::OP_SET_MODE, 32'h2);
		chk(tool.rx[31:0], 32'h5A5A_0F0F);
		chk({24'h0, tool.rx[39:32]}, 32'h0);
		tick(1);
		evt();
		rchk(dbg_pkg::OFF_STATUS, 32'h2);
		core_irq <= 1'b1;
		tick(3);
		chk({31'h0, core_halt}, 32'h0);
		rchk(dbg_pkg::OFF_STATUS, 32'h6);
		core_irq <= 1'b0;
		irq_done <= 1'b1;
		tick(1);
		irq_done <= 1'b0;
		tick(2);
		rchk(dbg_pkg::OFF_STATUS, 32'h2);
		chk({31'h0, core_halt}, 32'h1);
		chk(n_trig, 32'h4);
		done("wait");
		wrap_up();
	end
endmodule : tb_top

bind cpu_debug_logic dbg_asserts chk (.pclk, .presetn, .psel, .penable, .pready,
	.debug_event, .retire_valid, .retire_pc, .trace_out, .dbg_exception, .core_step,
	.core_halt, .fetch_valid, .fetch_addr, .ic_we, .ic_addr);
`default_nettype wire

// File: verilog/cpu_debug_logic.sv
// debug logic of an embedded core: apb registers, serial test port, run control, trace
// assumes core strobes are on pclk; serial pins arrive asynchronously and are oversampled
`timescale 1ns/1ps
`default_nettype none
module cpu_debug_logic (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic jtag_tck,
	input wire logic jtag_tms,
	input wire logic jtag_tdi,
	output logic jtag_tdo,
	output logic jtag_tdo_oe_n,
	input wire logic debug_event,
	input wire logic retire_valid,
	input wire logic [31:0] retire_pc,
	input wire logic core_irq,
	input wire logic irq_done,
	input wire logic [31:0] res_rdata,
	output logic core_halt,
	output logic core_step,
	output logic timer_freeze,
	output logic dbg_exception,
	output logic [31:0] res_addr,
	output logic [31:0] res_wdata,
	output logic res_we,
	output logic res_re,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic [31:0] fetch_data,
	output logic ic_we,
	output logic [31:0] ic_addr,
	output logic [31:0] ic_data,
	output dbg_pkg::trace_t trace_out
);

	// offsets that answer on the bus
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == dbg_pkg::OFF_CTRL) || (a == dbg_pkg::OFF_STATUS) ||
			(a == dbg_pkg::OFF_CMD) || (a == dbg_pkg::OFF_DATA) ||
			(a == dbg_pkg::OFF_BP) || (a == dbg_pkg::OFF_IRQ_STAT) ||
			(a == dbg_pkg::OFF_IRQ_MASK);
	endfunction : is_mapped

	dbg_pkg::mode_t mode, next_mode;
	dbg_pkg::state_t state, next_state;
	logic fetch_le, next_fetch_le;
	logic bp_en, next_bp_en;
	logic [31:0] bp_addr, next_bp_addr;
	logic [31:0] data_reg, next_data_reg;
	logic next_freeze;
	logic [31:0] next_res_addr, next_res_wdata;
	logic next_res_we, next_res_re;
	logic next_ic_we;
	logic [31:0] next_ic_addr, next_ic_data;
	logic [dbg_pkg::IRQ_BITS-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_ev;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq;
	logic next_halt, next_step, next_exc;
	dbg_pkg::trace_t next_trace;

	// serial pin sampling: tck, tms, tdi in bits 0..2
	logic [2:0] pin_s1, pin_s2, pin_s3, pin_f, next_pin_f;
	logic tck_rise, tck_fall;
	logic [dbg_pkg::FRAME_BITS-1:0] jsh, next_jsh, j_word;
	logic [5:0] jcnt, next_jcnt;
	logic next_tdo, next_tdo_oe_n, j_go;

	logic wr_acc, apb_go, cmd_go, dbg_evt, bp_hit;
	dbg_pkg::cmd_t cmd;
	logic [7:0] status_byte;

	// a pin change counts once the second and third stage agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pin
			assign next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1 <= dbg_pkg::PIN_IDLE; // idle levels avoid a false frame after reset
			pin_s2 <= dbg_pkg::PIN_IDLE;
			pin_s3 <= dbg_pkg::PIN_IDLE;
			pin_f <= dbg_pkg::PIN_IDLE;
		end
		else
		begin
			pin_s1 <= {jtag_tdi, jtag_tms, jtag_tck};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= next_pin_f;
		end
	end

	assign tck_rise = next_pin_f[0] & ~pin_f[0];
	assign tck_fall = ~next_pin_f[0] & pin_f[0];
	assign j_word = {jsh[dbg_pkg::FRAME_BITS-2:0], next_pin_f[2]};
	assign status_byte = {4'h0, timer_freeze, state};

	// serial frame: tms low frames it, tdi shifts in on tck rise, tdo moves on tck fall
	always_comb
	begin
		next_jsh = jsh;
		next_jcnt = jcnt;
		next_tdo = jtag_tdo;
		next_tdo_oe_n = 1'b1;
		j_go = 1'b0;
		if (next_pin_f[1])
		begin
			next_jcnt = 6'h0; // tms high aborts a partial frame
		end
		else
		begin
			next_tdo_oe_n = 1'b0;
			if (tck_rise)
			begin
				next_jsh = j_word;
				if (jcnt == 6'(dbg_pkg::FRAME_BITS - 1))
				begin
					j_go = 1'b1;
					next_jcnt = 6'h0;
					next_jsh = {status_byte, data_reg}; // reply shifts out next frame
				end
				else
				begin
					next_jcnt = jcnt + 6'h1;
				end
			end
		end
		// the closing fall comes with tms high; it must still present the reply msb
		if (tck_fall)
		begin
			next_tdo = jsh[dbg_pkg::FRAME_BITS-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			jsh <= {dbg_pkg::FRAME_BITS{1'b0}};
			jcnt <= 6'h0;
			jtag_tdo <= 1'b0;
			jtag_tdo_oe_n <= 1'b1;
		end
		else
		begin
			jsh <= next_jsh;
			jcnt <= next_jcnt;
			jtag_tdo <= next_tdo;
			jtag_tdo_oe_n <= next_tdo_oe_n;
		end
	end

	// software commands only act in internal mode; in the others the tool owns the core
	assign wr_acc = psel & penable & pready & pwrite;
	assign apb_go = wr_acc & (paddr == dbg_pkg::OFF_CMD) & (mode == dbg_pkg::MODE_INTERNAL);
	assign cmd_go = j_go | apb_go;
	assign cmd = j_go ? dbg_pkg::cmd_t'(j_word) : {pwdata[7:0], data_reg};
	assign bp_hit = bp_en & retire_valid & (retire_pc == bp_addr);
	assign dbg_evt = (debug_event | bp_hit) & (state == dbg_pkg::ST_RUN);

	// apb slave: decode in setup, answer in the first access cycle
	always_comb
	begin
		next_pready = psel & ~penable;
		next_pslverr = psel & ~penable & ~is_mapped(paddr);
		next_prdata = 32'h0000_0000;
		if (psel & ~penable & ~pwrite)
		begin
			case (paddr)
				dbg_pkg::OFF_CTRL: next_prdata = {28'h000_0000, bp_en, fetch_le, mode};
				dbg_pkg::OFF_STATUS: next_prdata = {28'h000_0000, timer_freeze, state};
				dbg_pkg::OFF_DATA: next_prdata = data_reg;
				dbg_pkg::OFF_BP: next_prdata = bp_addr;
				dbg_pkg::OFF_IRQ_STAT: next_prdata = {29'h0000_0000, irq_stat};
				dbg_pkg::OFF_IRQ_MASK: next_prdata = {29'h0000_0000, irq_mask};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// configuration, resource access and instruction cache port
	always_comb
	begin
		next_mode = mode;
		next_fetch_le = fetch_le;
		next_bp_en = bp_en;
		next_bp_addr = bp_addr;
		next_data_reg = data_reg;
		next_freeze = timer_freeze;
		next_res_addr = res_addr;
		next_res_wdata = res_wdata;
		next_res_we = 1'b0;
		next_res_re = 1'b0;
		next_ic_we = 1'b0;
		next_ic_addr = ic_addr;
		next_ic_data = ic_data;
		if (res_re)
		begin
			next_data_reg = res_rdata;
		end
		if (wr_acc)
		begin
			case (paddr)
				dbg_pkg::OFF_CTRL:
				begin
					if (pwdata[dbg_pkg::CTRL_MODE_LSB+:2] != 2'b11)
					begin
						next_mode = dbg_pkg::mode_t'(pwdata[dbg_pkg::CTRL_MODE_LSB+:2]);
					end
					next_fetch_le = pwdata[dbg_pkg::CTRL_LE_BIT];
					next_bp_en = pwdata[dbg_pkg::CTRL_BP_EN_BIT];
				end
				dbg_pkg::OFF_DATA: next_data_reg = pwdata;
				dbg_pkg::OFF_BP: next_bp_addr = pwdata;
				default: ;
			endcase
		end
		if (cmd_go)
		begin
			case (cmd.op)
				dbg_pkg::OP_FREEZE: next_freeze = 1'b1;
				dbg_pkg::OP_THAW: next_freeze = 1'b0;
				dbg_pkg::OP_SET_ADDR: next_res_addr = cmd.arg;
				dbg_pkg::OP_RES_WR:
				begin
					next_res_wdata = cmd.arg;
					next_res_we = 1'b1;
				end
				dbg_pkg::OP_RES_RD: next_res_re = 1'b1;
				dbg_pkg::OP_IC_WR:
				begin
					next_ic_we = 1'b1;
					next_ic_addr = res_addr;
					next_ic_data = cmd.arg;
					next_res_addr = res_addr + dbg_pkg::IC_ADDR_STEP; // streams code words
				end
				dbg_pkg::OP_SET_BP:
				begin
					next_bp_addr = cmd.arg;
					next_bp_en = 1'b1;
				end
				dbg_pkg::OP_SET_MODE:
				begin
					if (cmd.arg[1:0] != 2'b11)
					begin
						next_mode = dbg_pkg::mode_t'(cmd.arg[1:0]);
					end
				end
				default: ;
			endcase
		end
		// debug writes win the cache port; OP_IC_WR is taken in any state, so a fetch in the same cycle is dropped
		if (fetch_valid & ~next_ic_we)
		begin
			next_ic_we = 1'b1;
			next_ic_addr = fetch_addr;
			next_ic_data = fetch_le ? {fetch_data[7:0], fetch_data[15:8], fetch_data[23:16],
				fetch_data[31:24]} : fetch_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode <= dbg_pkg::MODE_INTERNAL;
			fetch_le <= 1'b0;
			bp_en <= 1'b0;
			bp_addr <= dbg_pkg::BP_RST;
			data_reg <= dbg_pkg::DATA_RST;
			timer_freeze <= 1'b0;
			res_addr <= 32'h0000_0000;
			res_wdata <= 32'h0000_0000;
			res_we <= 1'b0;
			res_re <= 1'b0;
			ic_we <= 1'b0;
			ic_addr <= 32'h0000_0000;
			ic_data <= 32'h0000_0000;
		end
		else
		begin
			mode <= next_mode;
			fetch_le <= next_fetch_le;
			bp_en <= next_bp_en;
			bp_addr <= next_bp_addr;
			data_reg <= next_data_reg;
			timer_freeze <= next_freeze;
			res_addr <= next_res_addr;
			res_wdata <= next_res_wdata;
			res_we <= next_res_we;
			res_re <= next_res_re;
			ic_we <= next_ic_we;
			ic_addr <= next_ic_addr;
			ic_data <= next_ic_data;
		end
	end

	// run control
	always_comb
	begin
		next_state = state;
		next_step = 1'b0;
		next_exc = 1'b0;
		case (state)
			dbg_pkg::ST_RUN:
			begin
				if (dbg_evt)
				begin
					case (mode)
						dbg_pkg::MODE_EXTERNAL: next_state = dbg_pkg::ST_STOP;
						dbg_pkg::MODE_WAIT: next_state = dbg_pkg::ST_WAIT;
						default: next_exc = 1'b1;
					endcase
				end
			end
			dbg_pkg::ST_STOP, dbg_pkg::ST_WAIT:
			begin
				if (cmd_go & (cmd.op == dbg_pkg::OP_RUN))
				begin
					next_state = dbg_pkg::ST_RUN;
				end
				else if (cmd_go & (cmd.op == dbg_pkg::OP_STEP))
				begin
					next_state = dbg_pkg::ST_STEP;
					next_step = 1'b1;
				end
				else if ((state == dbg_pkg::ST_WAIT) & core_irq)
				begin
					next_state = dbg_pkg::ST_SERVICE;
				end
			end
			dbg_pkg::ST_STEP:
			begin
				if (retire_valid)
				begin
					next_state = (mode == dbg_pkg::MODE_WAIT) ? dbg_pkg::ST_WAIT : dbg_pkg::ST_STOP;
				end
			end
			dbg_pkg::ST_SERVICE:
			begin
				if (irq_done)
				begin
					next_state = dbg_pkg::ST_WAIT;
				end
			end
			default: next_state = dbg_pkg::ST_RUN;
		endcase
		next_halt = (next_state == dbg_pkg::ST_STOP) || (next_state == dbg_pkg::ST_WAIT);
		// trace runs in every mode and state
		next_trace.valid = retire_valid;
		next_trace.pc = retire_pc;
		next_trace.trigger = dbg_evt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= dbg_pkg::ST_RUN;
			core_halt <= 1'b0;
			core_step <= 1'b0;
			dbg_exception <= 1'b0;
			trace_out <= '0;
		end
		else
		begin
			state <= next_state;
			core_halt <= next_halt;
			core_step <= next_step;
			dbg_exception <= next_exc;
			trace_out <= next_trace;
		end
	end

	// sticky event bits; a new event wins over a write-one clear in the same cycle
	always_comb
	begin
		irq_ev = '0;
		irq_ev[dbg_pkg::IRQ_EVENT_BIT] = dbg_evt;
		irq_ev[dbg_pkg::IRQ_SERVICE_BIT] = (state == dbg_pkg::ST_WAIT) &
			(next_state == dbg_pkg::ST_SERVICE);
		irq_ev[dbg_pkg::IRQ_FRAME_BIT] = j_go;
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		if (wr_acc & (paddr == dbg_pkg::OFF_IRQ_STAT))
		begin
			next_irq_stat = irq_stat & ~pwdata[dbg_pkg::IRQ_BITS-1:0];
		end
		if (wr_acc & (paddr == dbg_pkg::OFF_IRQ_MASK))
		begin
			next_irq_mask = pwdata[dbg_pkg::IRQ_BITS-1:0];
		end
		next_irq_stat = next_irq_stat | irq_ev;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= '0;
			irq_mask <= dbg_pkg::IRQ_MASK_RST;
			irq <= 1'b0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq <= next_irq;
		end
	end

endmodule : cpu_debug_logic
`default_nettype wire

// File: verilog/dbg_pkg.sv
// constants, types and register map shared by the core debug logic
// assumes a 32-bit apb master and a core that reports retirement, events and interrupts
// What this block does
// - tool reads and writes every core resource
// - internal mode: event raises debug exception
// - external mode: event stops the core
// - stopped core accepts run, step, freeze, breakpoints
// - tool writes instructions into instruction cache
// - external mode commands travel over serial port
// - wait mode: event enters wait, not stop
// - wait state services interrupts, then returns
// - trace of retired instructions always on
// - debug event flags trace capture to tool
// - little-endian fetches stored byte-swapped
package dbg_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;
	localparam logic [7:0] OFF_BP = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LE_BIT = 2;
	localparam int CTRL_BP_EN_BIT = 3;

	// status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_FREEZE_BIT = 3;

	// interrupt status bits
	localparam int IRQ_EVENT_BIT = 0;
	localparam int IRQ_SERVICE_BIT = 1;
	localparam int IRQ_FRAME_BIT = 2;
	localparam int IRQ_BITS = 3;

	// reset values
	localparam logic [31:0] BP_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	// serial pin idle levels {tdi, tms, tck}: tms high, so reset sees no frame
	localparam logic [2:0] PIN_IDLE = 3'h2;

	// serial frame: 8-bit command then 32-bit argument, msb first
	localparam int FRAME_BITS = 40;
	localparam logic [31:0] IC_ADDR_STEP = 32'h0000_0004;

	// command codes
	localparam logic [7:0] OP_RUN = 8'h01;
	localparam logic [7:0] OP_STEP = 8'h02;
	localparam logic [7:0] OP_FREEZE = 8'h03;
	localparam logic [7:0] OP_THAW = 8'h04;
	localparam logic [7:0] OP_SET_ADDR = 8'h05;
	localparam logic [7:0] OP_RES_WR = 8'h06;
	localparam logic [7:0] OP_RES_RD = 8'h07;
	localparam logic [7:0] OP_IC_WR = 8'h08;
	localparam logic [7:0] OP_SET_BP = 8'h09;
	localparam logic [7:0] OP_SET_MODE = 8'h0A;

	typedef enum logic [1:0] {
		MODE_INTERNAL = 2'b00,
		MODE_EXTERNAL = 2'b01,
		MODE_WAIT = 2'b10
	} mode_t;

	// gray along run, stop, step, wait, service
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_STOP = 3'b001,
		ST_STEP = 3'b011,
		ST_WAIT = 3'b010,
		ST_SERVICE = 3'b110
	} state_t;

	typedef struct packed {
		logic [7:0] op;
		logic [31:0] arg;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic trigger;
		logic [31:0] pc;
	} trace_t;

endpackage : dbg_pkg
